//--- core/tsrb_pkg.sv
// Purpose: constants and carrier types for the low temperature register bank
// Assumes: 8-bit registers, 8-bit register addresses
// Notes: alias offsets share storage with their primary offsets
package tsrb_pkg;

    // register offsets
    localparam logic [7:0] OFF_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] OFF_REMOTE_TEMP_HI = 8'h01;
    localparam logic [7:0] OFF_ALERT_STATUS = 8'h02;
    localparam logic [7:0] OFF_MAIN_CFG = 8'h03;
    localparam logic [7:0] OFF_CONV_RATE = 8'h04;
    localparam logic [7:0] OFF_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] OFF_RSVD_A = 8'h06;
    localparam logic [7:0] OFF_REMOTE_HIGH_HI = 8'h07;
    localparam logic [7:0] OFF_REMOTE_LOW_HI = 8'h08;
    localparam logic [7:0] OFF_MAIN_CFG_ALIAS = 8'h09;
    localparam logic [7:0] OFF_CONV_RATE_ALIAS = 8'h0a;
    localparam logic [7:0] OFF_LOCAL_HIGH_ALIAS = 8'h0b;
    localparam logic [7:0] OFF_RSVD_B = 8'h0c;
    localparam logic [7:0] OFF_REMOTE_HIGH_ALIAS = 8'h0d;
    localparam logic [7:0] OFF_REMOTE_LOW_ALIAS = 8'h0e;
    localparam logic [7:0] OFF_SINGLE_CONV = 8'h0f;
    localparam logic [7:0] OFF_REMOTE_TEMP_LO = 8'h10;
    localparam logic [7:0] OFF_REMOTE_OFS_HI = 8'h11;
    localparam logic [7:0] OFF_REMOTE_OFS_LO = 8'h12;
    localparam logic [7:0] OFF_REMOTE_HIGH_LO = 8'h13;

    // reset values
    localparam logic [7:0] RST_MAIN_CFG = 8'h00;
    localparam logic [7:0] RST_CONV_RATE = 8'h08;
    localparam logic [7:0] RST_LOCAL_HIGH = 8'h46;
    localparam logic [7:0] RST_REMOTE_HIGH_HI = 8'h55;
    localparam logic [7:0] RST_REMOTE_LOW_HI = 8'h00;
    localparam logic [7:0] RST_REMOTE_OFS_HI = 8'h00;
    localparam logic [7:0] RST_REMOTE_OFS_LO = 8'h00;
    localparam logic [7:0] RST_REMOTE_HIGH_LO = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // field masks
    localparam logic [7:0] MASK_FRAC_FULL = 8'hf8;
    localparam logic [7:0] MASK_FRAC_COARSE = 8'he0;
    localparam logic [7:0] MASK_FRAC_STORE = 8'he0;
    localparam logic [7:0] MASK_CONV_RATE = 8'h0f;
    localparam logic [7:0] MASK_MAIN_CFG = 8'he7;

    // writable configuration set
    typedef struct packed {
        logic [7:0] main_cfg;
        logic [7:0] conv_rate;
        logic [7:0] local_high;
        logic [7:0] remote_high_hi;
        logic [7:0] remote_low_hi;
        logic [7:0] remote_ofs_hi;
        logic [7:0] remote_ofs_lo;
        logic [7:0] remote_high_lo;
    } tsrb_cfg_t;

    // measured values from the conversion engine
    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_temp_hi;
        logic [7:0] remote_temp_lo;
        logic [7:0] alert_status;
        logic filter_on;
        logic extended_fraction_enable;
    } tsrb_meas_t;

    // whole module state
    typedef struct packed {
        tsrb_cfg_t cfg;
        logic [7:0] rd_data;
        logic rd_valid;
        logic conv_start;
    } tsrb_state_t;

endpackage : tsrb_pkg

//--- core/tsrb_bank.sv
// Purpose: register bank 0x00..0x13 of a temperature sensor
// Assumes: access port and conversion engine share clk
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ns

module tsrb_bank
    import tsrb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // conversion engine side
    input wire tsrb_meas_t meas,
    output tsrb_cfg_t cfg,
    output logic conv_start
);

    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("tsrb_bank: ADDR_W must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // alias folding
    function automatic logic [7:0] fold_addr(input logic [7:0] a);
        unique case (a)
            OFF_MAIN_CFG_ALIAS: fold_addr = OFF_MAIN_CFG;
            OFF_CONV_RATE_ALIAS: fold_addr = OFF_CONV_RATE;
            OFF_LOCAL_HIGH_ALIAS: fold_addr = OFF_LOCAL_HIGH;
            OFF_REMOTE_HIGH_ALIAS: fold_addr = OFF_REMOTE_HIGH_HI;
            OFF_REMOTE_LOW_ALIAS: fold_addr = OFF_REMOTE_LOW_HI;
            default: fold_addr = a;
        endcase
    endfunction : fold_addr

    tsrb_state_t st_ff;
    tsrb_state_t nxt_st;
    logic [7:0] addr8;
    logic [7:0] eff_addr;
    logic addr_hi_zero;

    assign addr8 = reg_addr[7:0];
    assign addr_hi_zero = (reg_addr >> 8) == '0;
    assign eff_addr = addr_hi_zero ? fold_addr(addr8) : 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd_valid = reg_rd;
        nxt_st.conv_start = 1'b0;
        if (reg_rd) begin
            unique case (eff_addr)
                OFF_LOCAL_TEMP: nxt_st.rd_data = meas.local_temp;
                OFF_REMOTE_TEMP_HI: nxt_st.rd_data = meas.remote_temp_hi;
                OFF_ALERT_STATUS: nxt_st.rd_data = meas.alert_status;
                OFF_MAIN_CFG: nxt_st.rd_data = st_ff.cfg.main_cfg;
                OFF_CONV_RATE: nxt_st.rd_data = st_ff.cfg.conv_rate;
                OFF_LOCAL_HIGH: nxt_st.rd_data = st_ff.cfg.local_high;
                OFF_REMOTE_HIGH_HI: nxt_st.rd_data = st_ff.cfg.remote_high_hi;
                OFF_REMOTE_LOW_HI: nxt_st.rd_data = st_ff.cfg.remote_low_hi;
                OFF_REMOTE_TEMP_LO: begin
                    if (meas.filter_on || meas.extended_fraction_enable) begin
                        nxt_st.rd_data = meas.remote_temp_lo & MASK_FRAC_FULL;
                    end else begin
                        nxt_st.rd_data = meas.remote_temp_lo & MASK_FRAC_COARSE;
                    end
                end
                OFF_REMOTE_OFS_HI: nxt_st.rd_data = st_ff.cfg.remote_ofs_hi;
                OFF_REMOTE_OFS_LO: nxt_st.rd_data = st_ff.cfg.remote_ofs_lo;
                OFF_REMOTE_HIGH_LO: nxt_st.rd_data = st_ff.cfg.remote_high_lo;
                // reserved, trigger and unmapped read zero
                default: nxt_st.rd_data = RST_ZERO;
            endcase
        end
        if (reg_wr) begin
            unique case (eff_addr)
                OFF_MAIN_CFG: nxt_st.cfg.main_cfg = reg_wdata & MASK_MAIN_CFG;
                OFF_CONV_RATE: nxt_st.cfg.conv_rate = reg_wdata & MASK_CONV_RATE;
                OFF_LOCAL_HIGH: nxt_st.cfg.local_high = reg_wdata;
                OFF_REMOTE_HIGH_HI: nxt_st.cfg.remote_high_hi = reg_wdata;
                OFF_REMOTE_LOW_HI: nxt_st.cfg.remote_low_hi = reg_wdata;
                OFF_SINGLE_CONV: nxt_st.conv_start = 1'b1;
                OFF_REMOTE_OFS_HI: nxt_st.cfg.remote_ofs_hi = reg_wdata;
                OFF_REMOTE_OFS_LO: nxt_st.cfg.remote_ofs_lo = reg_wdata & MASK_FRAC_STORE;
                OFF_REMOTE_HIGH_LO: nxt_st.cfg.remote_high_lo = reg_wdata & MASK_FRAC_STORE;
                // read-only, reserved and unmapped writes dropped
                default: nxt_st.cfg = st_ff.cfg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff.cfg.main_cfg <= RST_MAIN_CFG;
            st_ff.cfg.conv_rate <= RST_CONV_RATE;
            st_ff.cfg.local_high <= RST_LOCAL_HIGH;
            st_ff.cfg.remote_high_hi <= RST_REMOTE_HIGH_HI;
            st_ff.cfg.remote_low_hi <= RST_REMOTE_LOW_HI;
            st_ff.cfg.remote_ofs_hi <= RST_REMOTE_OFS_HI;
            st_ff.cfg.remote_ofs_lo <= RST_REMOTE_OFS_LO;
            st_ff.cfg.remote_high_lo <= RST_REMOTE_HIGH_LO;
            st_ff.rd_data <= RST_ZERO;
            st_ff.rd_valid <= 1'b0;
            st_ff.conv_start <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rd_data;
    assign reg_rvalid = st_ff.rd_valid;
    assign cfg = st_ff.cfg;
    assign conv_start = st_ff.conv_start;

endmodule : tsrb_bank

//--- sim/tsrb_bank_chk_sva.sv
// Purpose: port checks for the low register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound into tsrb_bank
`timescale 1ns/1ns
module tsrb_bank_chk
    import tsrb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // engine side
    input wire tsrb_meas_t meas,
    input wire tsrb_cfg_t cfg,
    input wire logic conv_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    alias_write_a: assert property (
        reg_wr && reg_addr == OFF_MAIN_CFG_ALIAS |=> cfg.main_cfg == ($past(reg_wdata) & 8'he7))
        else $error("alias write lost");
    alias_read_a: assert property (
        reg_rd && reg_addr == OFF_REMOTE_HIGH_ALIAS |=>
        reg_rvalid && reg_rdata == $past(cfg.remote_high_hi)) else $error("alias read wrong");
    rsvd_zero_a: assert property (
        reg_rd && (reg_addr == OFF_RSVD_A || reg_addr == OFF_RSVD_B) |=> reg_rdata == 8'h00)
        else $error("reserved read nonzero");
    frac_read_a: assert property (
        reg_rd && reg_addr == OFF_REMOTE_TEMP_LO |=> reg_rdata == ($past(meas.remote_temp_lo) &
        ($past(meas.filter_on) || $past(meas.extended_fraction_enable) ? 8'hf8 : 8'he0)))
        else $error("fraction bits wrong");
    one_shot_a: assert property (
        reg_wr && reg_addr == OFF_SINGLE_CONV |=> conv_start && $stable(cfg))
        else $error("one shot missing");
    start_cause_a: assert property (
        conv_start |-> $past(reg_wr) && $past(reg_addr) == OFF_SINGLE_CONV)
        else $error("stray conversion start");
    cover property (reg_rd && reg_addr == OFF_REMOTE_TEMP_LO && meas.extended_fraction_enable);
    cover property (conv_start);
    cover property (reg_wr && reg_addr == OFF_REMOTE_HIGH_ALIAS);
endmodule : tsrb_bank_chk
bind tsrb_bank tsrb_bank_chk #(.ADDR_W(ADDR_W)) chk (.*);

//--- sim/tsrb_engine_model.sv
// Purpose: conversion engine stand-in
// Assumes: shares clk with the bank
// Notes: new random results after each start
`timescale 1ns/1ns
module tsrb_engine_model
    import tsrb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // conversion handshake
    input wire logic conv_start,
    output tsrb_meas_t meas,
    output int n_conv
);
    always @(negedge clk) begin
        if (!rst_n) begin
            meas <= '0;
            n_conv <= 0;
        end else if (conv_start === 1'b1) begin
            meas <= tsrb_meas_t'({$urandom, 2'($urandom)});
            n_conv <= n_conv + 1;
        end
    end
endmodule : tsrb_engine_model

//--- sim/tb_top.sv
// Purpose: self-checking bench for the low register bank
// Assumes: host drives the port at falling edges
// Notes: reads checked from a queue of expected data
`timescale 1ns/1ns
module tb_top
    import tsrb_pkg::*;
;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] reg_addr = '0;
    logic reg_wr = 0;
    logic [7:0] reg_wdata = '0;
    logic reg_rd = 0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic conv_start;
    tsrb_meas_t meas;
    tsrb_cfg_t cfg;
    int n_conv;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] exp_q[$];
    logic [7:0] pri[8] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13};
    logic [7:0] ali[8] = '{8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13};
    logic [7:0] msk[8] = '{8'he7, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'he0, 8'he0};
    logic [7:0] rstv[8] = '{8'h00, 8'h08, 8'h46, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] sh[8];
    logic [7:0] x[2] = '{8'h0c, 8'h0f};
    logic [7:0] d;
    tsrb_bank #(.ADDR_W(8)) dut (.*);
    tsrb_engine_model eng (.*);
    always #2 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [7:0] a, input logic w, input logic [7:0] v, input logic r);
        @(negedge clk);
        reg_addr <= a;
        reg_wr <= w;
        reg_wdata <= v;
        reg_rd <= r;
    endtask : op
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(a, 1'b0, 8'h00, 1'b1);
    endtask : rd
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            chk(reg_rdata, exp_q.size() ? exp_q.pop_front() : ~reg_rdata);
        end
    end
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(24));
        repeat (8) @(negedge clk);
        rst_n <= 1;
        for (int i = 0; i < 8; i++) begin
            rd(pri[i], rstv[i]);
            rd(ali[i], rstv[i]);
            d = 8'($urandom);
            op(ali[i], 1'b1, d, 1'b0);
            rd(pri[i], d & msk[i]);
            d = 8'($urandom);
            op(pri[i], 1'b1, d, 1'b0);
            sh[i] = d & msk[i];
            rd(ali[i], sh[i]);
        end
        $display("alias test done");
        op(8'h0f, 1'b1, 8'($urandom), 1'b0);
        foreach (x[i]) rd(x[i], 8'h00);
        $display("reserved test done");
        for (int k = 0; k < 8; k++) begin
            op(8'h0f, 1'b1, 8'($urandom), 1'b0);
            op(8'h00, 1'b0, 8'h00, 1'b0);
            repeat (3) @(negedge clk);
            rd(8'h10, meas.remote_temp_lo &
                (meas.filter_on | meas.extended_fraction_enable ? 8'hf8 : 8'he0));
        end
        foreach (sh[i]) rd(pri[i], sh[i]);
        op(8'h00, 1'b0, 8'h00, 1'b0);
        repeat (4) @(negedge clk);
        chk(8'(n_conv), 8'h09);
        chk(8'(exp_q.size()), 8'h00);
        $display("one shot test done");
        final_report();
    end
endmodule : tb_top
